// ---- core/tmc_defs.svh ----
// Offsets, field positions, reset values and scale figures of the main configuration bank.
`ifndef TMC_DEFS_SVH
`define TMC_DEFS_SVH

// ==========================================================================
// Register offsets (byte addresses within the bank).
`define TMC_OFS_STATE_BAND 2'h0
`define TMC_OFS_MOD_PATH 2'h1
`define TMC_OFS_DEV_CODE 2'h2
`define TMC_OFS_BR_CODE 2'h3

// ==========================================================================
// Field positions, byte 0.
`define TMC_STATE_MSB 7
`define TMC_STATE_LSB 5
`define TMC_BAND_MSB 4
`define TMC_BAND_LSB 3
`define TMC_TRIM_MSB 2
`define TMC_TRIM_LSB 1
`define TMC_DIVSEL_BIT 0

// Field positions, byte 1.
`define TMC_MOD_MSB 7
`define TMC_MOD_LSB 6
`define TMC_PATH_LSB_BIT 5
`define TMC_SLICER_MSB 4
`define TMC_SLICER_LSB 3
`define TMC_PATH_MSB_BIT 2
`define TMC_IFGAIN_MSB 1
`define TMC_IFGAIN_LSB 0

// Field positions, byte 3.
`define TMC_BR_RES_BIT 7
`define TMC_BR_MSB 6
`define TMC_BR_LSB 0

// ==========================================================================
// Reset values of the four bytes.
`define TMC_RST_STATE_BAND 8'h28
`define TMC_RST_MOD_PATH 8'h88
`define TMC_RST_DEV_CODE 8'h03
`define TMC_RST_BR_CODE 8'h07

// ==========================================================================
// Scale figures: IF step in tenths of a dB, divisor shifts (32 and 64).
`define TMC_IF_STEP_TENTH_DB 8'h2D
`define TMC_DEV_SHIFT 5
`define TMC_BR_SHIFT 6

`endif

// ---- core/tmc_pkg.sv ----
// Types shared by the main configuration bank modules.
package tmc_pkg;

    // ======================================================================
    // Decoded operating state.
    typedef enum logic [2:0] {
        TMC_ST_SLEEP,
        TMC_ST_STANDBY,
        TMC_ST_SYNTH_ONLY,
        TMC_ST_RX,
        TMC_ST_TX,
        TMC_ST_UNLISTED
    } tmc_op_state_t;

    // Decoded modulation type.
    typedef enum logic [1:0] {
        TMC_MOD_OOK,
        TMC_MOD_FSK,
        TMC_MOD_UNLISTED
    } tmc_mod_t;

    // Decoded data-path mode.
    typedef enum logic [1:0] {
        TMC_PATH_CONTINUOUS,
        TMC_PATH_BUFFERED,
        TMC_PATH_PACKET
    } tmc_path_t;

    // Decoded on-off slicer threshold kind.
    typedef enum logic [1:0] {
        TMC_SLC_FIXED,
        TMC_SLC_PEAK,
        TMC_SLC_AVERAGE,
        TMC_SLC_RESERVED
    } tmc_slicer_t;

    // Whole state of the register bank.
    typedef struct packed {
        logic [7:0] state_band;
        logic [7:0] mod_path;
        logic [7:0] dev_code;
        logic [7:0] br_code;
        logic [7:0] rdata;
        logic [13:0] dev_div;
        logic [13:0] br_div;
    } tmc_state_t;

endpackage

// ---- core/tmc_field_decode.sv ----
// Decoder from the raw bytes 0 and 1 to operating controls.
`timescale 1ns/100ps
`include "tmc_defs.svh"

module tmc_field_decode (
    input wire logic [7:0] state_band_i,
    input wire logic [7:0] mod_path_i,
    output tmc_pkg::tmc_op_state_t op_state_o,
    output tmc_pkg::tmc_mod_t modulation_o,
    output tmc_pkg::tmc_path_t datapath_o,
    output tmc_pkg::tmc_slicer_t onoff_slicer_kind_o,
    output logic [7:0] if_atten_tenth_db_o
);
    import tmc_pkg::*;

    logic [2:0] state_code;
    logic [1:0] mod_code;
    logic [1:0] slicer_code;
    logic [1:0] if_code;

    // ======================================================================
    // Field extraction.
    assign state_code = state_band_i[`TMC_STATE_MSB:`TMC_STATE_LSB];
    assign mod_code = mod_path_i[`TMC_MOD_MSB:`TMC_MOD_LSB];
    assign slicer_code = mod_path_i[`TMC_SLICER_MSB:`TMC_SLICER_LSB];
    assign if_code = mod_path_i[`TMC_IFGAIN_MSB:`TMC_IFGAIN_LSB];

    // Operating state; codes above transmit are flagged as unlisted.
    always_comb begin
        unique case (state_code)
            3'h0: op_state_o = TMC_ST_SLEEP; // [RULE1]
            3'h1: op_state_o = TMC_ST_STANDBY; // [RULE1]
            3'h2: op_state_o = TMC_ST_SYNTH_ONLY; // [RULE1]
            3'h3: op_state_o = TMC_ST_RX; // [RULE1]
            3'h4: op_state_o = TMC_ST_TX; // [RULE1]
            default: op_state_o = TMC_ST_UNLISTED;
        endcase
    end

    // Modulation type; codes 00 and 11 are flagged as unlisted.
    always_comb begin
        unique case (mod_code)
            2'h1: modulation_o = TMC_MOD_OOK; // [RULE4]
            2'h2: modulation_o = TMC_MOD_FSK; // [RULE4]
            default: modulation_o = TMC_MOD_UNLISTED;
        endcase
    end

    // Data path: the high bit forces packet mode whatever the low bit is.
    always_comb begin
        if (mod_path_i[`TMC_PATH_MSB_BIT]) begin
            datapath_o = TMC_PATH_PACKET; // [RULE5]
        end else if (mod_path_i[`TMC_PATH_LSB_BIT]) begin
            datapath_o = TMC_PATH_BUFFERED; // [RULE5]
        end else begin
            datapath_o = TMC_PATH_CONTINUOUS; // [RULE5]
        end
    end

    // Slicer threshold kind; all four codes are decodable.
    always_comb begin
        unique case (slicer_code)
            2'h0: onoff_slicer_kind_o = TMC_SLC_FIXED; // [RULE6]
            2'h1: onoff_slicer_kind_o = TMC_SLC_PEAK; // [RULE6]
            2'h2: onoff_slicer_kind_o = TMC_SLC_AVERAGE; // [RULE6]
            2'h3: onoff_slicer_kind_o = TMC_SLC_RESERVED; // [RULE6]
        endcase
    end

    // IF attenuation in tenths of a dB, 45 per step, at most 135.
    assign if_atten_tenth_db_o = {6'h00, if_code} * `TMC_IF_STEP_TENTH_DB; // [RULE7]

endmodule // tmc_field_decode

// ---- core/tmc_main_config_regs.sv ----
// Main configuration bank, bytes 0 to 3: storage, read-back and decoded controls.
`timescale 1ns/100ps
`include "tmc_defs.svh"

// ==========================================================================
// Summary of operation
// RULE1 - Byte 0 bits 7-5 select operating state.
// RULE2 - Byte 0 bits 2-1 oscillator fine trim.
// RULE3 - Byte 0 bit 0 selects divider set.
// RULE4 - Byte 1 bits 7-6: OOK or FSK.
// RULE5 - Bits 2 and 5 pick data-path mode.
// RULE6 - Byte 1 bits 4-3 slicer threshold kind.
// RULE7 - IF attenuation in 4.5 dB steps.
// RULE8 - Deviation divisor is 32 times (D+1).
// RULE9 - Bit-rate divisor is 64 times (C+1).
// RULE10 - Software writes only listed codes.
module tmc_main_config_regs (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic wr_en_i,
    input wire logic rd_en_i,
    input wire logic [1:0] addr_i,
    input wire logic [7:0] wdata_i,
    output logic [7:0] rdata_o,
    output tmc_pkg::tmc_op_state_t op_state_o,
    output logic [1:0] band_sel_o,
    output logic [1:0] osc_fine_trim_o,
    output logic divider_set_sel_o,
    output tmc_pkg::tmc_mod_t modulation_o,
    output tmc_pkg::tmc_path_t datapath_o,
    output tmc_pkg::tmc_slicer_t onoff_slicer_kind_o,
    output logic [1:0] if_gain_step_o,
    output logic [7:0] if_atten_tenth_db_o,
    output logic [7:0] fsk_deviation_code_o,
    output logic [13:0] deviation_divisor_o,
    output logic [6:0] bitrate_divisor_o,
    output logic [13:0] bitrate_clock_divisor_o
);
    import tmc_pkg::*;

    tmc_state_t state_q;
    tmc_state_t state_d;
    logic [13:0] dev_plus_one;
    logic [13:0] br_plus_one;
    // Copy of the raw state field, used by the decode checks below.
    logic [2:0] rdata_chk_state;

    // ======================================================================
    // Next-state logic: byte writes, read-back capture and divisor update.
    always_comb begin
        state_d = state_q;
        dev_plus_one = 14'h0000;
        br_plus_one = 14'h0000;
        // A write lands at the next edge; software keeps codes listed.
        if (wr_en_i) begin // [RULE10]
            unique case (addr_i)
                `TMC_OFS_STATE_BAND: state_d.state_band = wdata_i; // [RULE1] [RULE2] [RULE3]
                `TMC_OFS_MOD_PATH: state_d.mod_path = wdata_i; // [RULE4] [RULE5] [RULE6] [RULE7]
                `TMC_OFS_DEV_CODE: state_d.dev_code = wdata_i; // [RULE8]
                `TMC_OFS_BR_CODE: state_d.br_code = wdata_i; // [RULE9]
            endcase
        end
        // A read captures the value held before any write of the same cycle.
        if (rd_en_i) begin
            unique case (addr_i)
                `TMC_OFS_STATE_BAND: state_d.rdata = state_q.state_band;
                `TMC_OFS_MOD_PATH: state_d.rdata = state_q.mod_path;
                `TMC_OFS_DEV_CODE: state_d.rdata = state_q.dev_code;
                `TMC_OFS_BR_CODE: state_d.rdata = state_q.br_code;
            endcase
        end
        // Divisors follow the stored codes in the same edge as the byte.
        dev_plus_one = {6'h00, state_d.dev_code} + 14'h0001;
        br_plus_one = {7'h00, state_d.br_code[`TMC_BR_MSB:`TMC_BR_LSB]} + 14'h0001;
        state_d.dev_div = dev_plus_one << `TMC_DEV_SHIFT; // [RULE8]
        state_d.br_div = br_plus_one << `TMC_BR_SHIFT; // [RULE9]
    end

    // ======================================================================
    // State register with synchronous reset to the documented defaults.
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            state_q.state_band <= `TMC_RST_STATE_BAND; // [RULE1] [RULE2] [RULE3]
            state_q.mod_path <= `TMC_RST_MOD_PATH; // [RULE4] [RULE5] [RULE6] [RULE7]
            state_q.dev_code <= `TMC_RST_DEV_CODE; // [RULE8]
            state_q.br_code <= `TMC_RST_BR_CODE; // [RULE9]
            state_q.rdata <= 8'h00;
            state_q.dev_div <= 14'h0080;
            state_q.br_div <= 14'h0200;
        end else begin
            state_q <= state_d;
        end
    end

    // ======================================================================
    // Field decode of bytes 0 and 1.
    tmc_field_decode u_decode (
        .state_band_i(state_q.state_band),
        .mod_path_i(state_q.mod_path),
        .op_state_o(op_state_o),
        .modulation_o(modulation_o),
        .datapath_o(datapath_o),
        .onoff_slicer_kind_o(onoff_slicer_kind_o),
        .if_atten_tenth_db_o(if_atten_tenth_db_o)
    );

    // ======================================================================
    // Raw fields and divisors, all straight from flip-flops.
    assign rdata_o = state_q.rdata;
    assign band_sel_o = state_q.state_band[`TMC_BAND_MSB:`TMC_BAND_LSB];
    assign osc_fine_trim_o = state_q.state_band[`TMC_TRIM_MSB:`TMC_TRIM_LSB]; // [RULE2]
    assign divider_set_sel_o = state_q.state_band[`TMC_DIVSEL_BIT]; // [RULE3]
    assign if_gain_step_o = state_q.mod_path[`TMC_IFGAIN_MSB:`TMC_IFGAIN_LSB]; // [RULE7]
    assign fsk_deviation_code_o = state_q.dev_code; // [RULE8]
    assign deviation_divisor_o = state_q.dev_div; // [RULE8]
    assign bitrate_divisor_o = state_q.br_code[`TMC_BR_MSB:`TMC_BR_LSB]; // [RULE9]
    assign bitrate_clock_divisor_o = state_q.br_div; // [RULE9]
    assign rdata_chk_state = state_q.state_band[`TMC_STATE_MSB:`TMC_STATE_LSB];

    // ======================================================================
    // Checks on reset values, decode and divisor arithmetic.

    // After reset the bank shows standby, FSK, peak slicer and the default codes.
    a_reset_defaults: assert property (@(posedge clock_i) // [RULE1]
        !rst_n_i |=> (op_state_o == TMC_ST_STANDBY) && (modulation_o == TMC_MOD_FSK)
            && (onoff_slicer_kind_o == TMC_SLC_PEAK) && (datapath_o == TMC_PATH_CONTINUOUS)
            && (osc_fine_trim_o == 2'h0) && !divider_set_sel_o && (if_gain_step_o == 2'h0)
            && (fsk_deviation_code_o == 8'h03) && (bitrate_divisor_o == 7'h07))
        else $error("bank did not return to its defaults after reset");

    // Writing state code 011 to byte 0 shows receive on the next cycle.
    a_state_rx_write: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [RULE1]
        (wr_en_i && (addr_i == 2'h0) && (wdata_i[7:5] == 3'h3)) |=> (op_state_o == TMC_ST_RX))
        else $error("state code 011 did not decode to receive");

    // Transmit is shown exactly while the state field holds 100.
    a_state_tx_decode: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [RULE1]
        (op_state_o == TMC_ST_TX) == (rdata_chk_state == 3'h4))
        else $error("transmit decode does not match the state field");

    // The trim field follows the written bits 2-1.
    a_trim_follow: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [RULE2]
        (wr_en_i && (addr_i == 2'h0)) |=> (osc_fine_trim_o == $past(wdata_i[2:1])))
        else $error("trim field did not follow the write");

    // The divider-set select follows the written bit 0.
    a_divsel_follow: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [RULE3]
        (wr_en_i && (addr_i == 2'h0)) |=> (divider_set_sel_o == $past(wdata_i[0])))
        else $error("divider-set select wrong after write");

    // Without a write to byte 0 the divider-set select keeps its value.
    a_divsel_hold: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [RULE3]
        !(wr_en_i && (addr_i == 2'h0)) |=> $stable(divider_set_sel_o))
        else $error("divider-set select changed without a write");

    // Code 01 in byte 1 bits 7-6 selects on-off keying.
    a_mod_ook: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [RULE4]
        (wr_en_i && (addr_i == 2'h1) && (wdata_i[7:6] == 2'h1)) |=> (modulation_o == TMC_MOD_OOK))
        else $error("modulation code 01 not decoded as on-off keying");

    // Packet mode whenever bit 2 is set, whatever bit 5 holds.
    a_packet_mode: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [RULE5]
        (wr_en_i && (addr_i == 2'h1) && wdata_i[2]) |=> (datapath_o == TMC_PATH_PACKET))
        else $error("bit 2 set but data path is not packet");

    // Buffered mode when bit 2 is low and bit 5 is high.
    a_buffered_mode: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [RULE5]
        (wr_en_i && (addr_i == 2'h1) && !wdata_i[2] && wdata_i[5])
            |=> (datapath_o == TMC_PATH_BUFFERED))
        else $error("buffered data path not decoded");

    // Slicer code 10 selects average mode.
    a_slicer_avg: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [RULE6]
        (wr_en_i && (addr_i == 2'h1) && (wdata_i[4:3] == 2'h2))
            |=> (onoff_slicer_kind_o == TMC_SLC_AVERAGE))
        else $error("slicer code 10 not decoded as average");

    // IF code 11 gives 13.5 dB of attenuation.
    a_if_atten: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [RULE7]
        (if_gain_step_o == 2'h3) |-> (if_atten_tenth_db_o == 8'h87))
        else $error("IF code 11 not at 13.5 dB attenuation");

    // A deviation code write gives a divisor of 32 times the code plus one.
    a_dev_divisor: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [RULE8]
        (wr_en_i && (addr_i == 2'h2))
            |=> (deviation_divisor_o == (({6'h00, $past(wdata_i)} + 14'h0001) * 14'h0020)))
        else $error("deviation divisor wrong after write");

    // A bit-rate code write gives a divisor of 64 times the code plus one.
    a_br_divisor: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [RULE9]
        (wr_en_i && (addr_i == 2'h3))
            |=> (bitrate_clock_divisor_o
                == (({7'h00, $past(wdata_i[6:0])} + 14'h0001) * 14'h0040)))
        else $error("bit-rate divisor wrong after write");

    // A read of byte 2 returns the code held when the read was issued.
    a_read_back: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [RULE8]
        rd_en_i && (addr_i == 2'h2) |=> (rdata_o == $past(fsk_deviation_code_o)))
        else $error("read-back of byte 2 wrong");

    // Synthesizer-only is shown exactly while the state field holds 010.
    a_state_synth: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [RULE1]
        (op_state_o == TMC_ST_SYNTH_ONLY) == (rdata_chk_state == 3'h2))
        else $error("synthesizer-only decode does not match the state field");

    // Code 10 in byte 1 bits 7-6 selects frequency-shift keying.
    a_mod_fsk: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [RULE4]
        (wr_en_i && (addr_i == 2'h1) && (wdata_i[7:6] == 2'h2)) |=> (modulation_o == TMC_MOD_FSK))
        else $error("modulation code 10 not decoded as frequency-shift keying");

    // Continuous mode when both path bits are low.
    a_continuous_mode: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [RULE5]
        (wr_en_i && (addr_i == 2'h1) && !wdata_i[2] && !wdata_i[5])
            |=> (datapath_o == TMC_PATH_CONTINUOUS))
        else $error("continuous data path not decoded");

    // Slicer code 00 selects the fixed threshold.
    a_slicer_fixed: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [RULE6]
        (wr_en_i && (addr_i == 2'h1) && (wdata_i[4:3] == 2'h0))
            |=> (onoff_slicer_kind_o == TMC_SLC_FIXED))
        else $error("slicer code 00 not decoded as fixed");

    // The deviation divisor holds while byte 2 is not written.
    a_dev_hold: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [RULE8]
        !(wr_en_i && (addr_i == 2'h2)) |=> $stable(deviation_divisor_o))
        else $error("deviation divisor changed without a write");

    // The bit-rate divisor holds while byte 3 is not written.
    a_br_hold: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [RULE9]
        !(wr_en_i && (addr_i == 2'h3)) |=> $stable(bitrate_clock_divisor_o))
        else $error("bit-rate divisor changed without a write");

endmodule // tmc_main_config_regs

// ---- testbench/tmc_main_config_regs_tb.sv ----
// Self-checking testbench of the main configuration bank, bytes 0 to 3.
`timescale 1ns/100ps

module tmc_main_config_regs_tb;
    import tmc_pkg::*;

    // ======================================================================
    // Signals, clock and the shared compare.
    logic clock_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic wr_en_i = 1'b0;
    logic rd_en_i = 1'b0;
    logic [1:0] addr_i = 2'h0;
    logic [7:0] wdata_i = 8'h00;
    logic [7:0] rdata_o;
    tmc_op_state_t op_state_o;
    logic [1:0] band_sel_o;
    logic [1:0] osc_fine_trim_o;
    logic divider_set_sel_o;
    tmc_mod_t modulation_o;
    tmc_path_t datapath_o;
    tmc_slicer_t onoff_slicer_kind_o;
    logic [1:0] if_gain_step_o;
    logic [7:0] if_atten_tenth_db_o;
    logic [7:0] fsk_deviation_code_o;
    logic [13:0] deviation_divisor_o;
    logic [6:0] bitrate_divisor_o;
    logic [13:0] bitrate_clock_divisor_o;
    int miscompares = 0;
    int n_checks = 0;

`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin miscompares++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, (got), (exp)); end end

    // The clock toggles every half period of 2.5 ns.
    initial begin
        forever #2.5 clock_i = ~clock_i;
    end

    tmc_main_config_regs u_tmc_main_config_regs (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .wr_en_i(wr_en_i), .rd_en_i(rd_en_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .rdata_o(rdata_o), .op_state_o(op_state_o),
        .band_sel_o(band_sel_o), .osc_fine_trim_o(osc_fine_trim_o),
        .divider_set_sel_o(divider_set_sel_o), .modulation_o(modulation_o),
        .datapath_o(datapath_o), .onoff_slicer_kind_o(onoff_slicer_kind_o),
        .if_gain_step_o(if_gain_step_o), .if_atten_tenth_db_o(if_atten_tenth_db_o),
        .fsk_deviation_code_o(fsk_deviation_code_o),
        .deviation_divisor_o(deviation_divisor_o), .bitrate_divisor_o(bitrate_divisor_o),
        .bitrate_clock_divisor_o(bitrate_clock_divisor_o)
    );

    // ======================================================================
    // Access tasks: requests change at the falling edge, one strobe cycle each.
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(negedge clock_i);
        wr_en_i = 1'b1;
        addr_i = a;
        wdata_i = d;
        @(negedge clock_i);
        wr_en_i = 1'b0;
    endtask

    // Reads one byte; the data is settled one edge after the strobe is taken.
    task automatic rd(input logic [1:0] a, input logic [7:0] e);
        @(negedge clock_i);
        rd_en_i = 1'b1;
        addr_i = a;
        @(negedge clock_i);
        rd_en_i = 1'b0;
        `CHK(rdata_o, e)
    endtask

    // Holds reset low for a number of cycles, then releases it.
    task automatic do_reset(input int n);
        @(negedge clock_i);
        rst_n_i = 1'b0;
        repeat (n) @(negedge clock_i);
        rst_n_i = 1'b1;
    endtask

    // Checks every field against the documented defaults.
    task automatic chk_defaults();
        `CHK(rdata_o, 8'h00)
        `CHK(op_state_o, TMC_ST_STANDBY)
        `CHK(band_sel_o, 2'h1)
        `CHK(osc_fine_trim_o, 2'h0)
        `CHK(divider_set_sel_o, 1'b0)
        `CHK(modulation_o, TMC_MOD_FSK)
        `CHK(datapath_o, TMC_PATH_CONTINUOUS)
        `CHK(onoff_slicer_kind_o, TMC_SLC_PEAK)
        `CHK(if_atten_tenth_db_o, 8'h00)
        `CHK(if_gain_step_o, 2'h0)
        `CHK(fsk_deviation_code_o, 8'h03)
        `CHK(bitrate_divisor_o, 7'h07)
        `CHK(deviation_divisor_o, 14'h0080)
        `CHK(bitrate_clock_divisor_o, 14'h0200)
        rd(2'h0, 8'h28);
        rd(2'h1, 8'h88);
        rd(2'h2, 8'h03);
        rd(2'h3, 8'h07);
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic close_out();
        $display("checks=%0d miscompares=%0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // ======================================================================
    // Watchdog: the tests need well under 400 cycles.
    initial begin
        repeat (2000) @(posedge clock_i);
        miscompares++;
        close_out();
    end

    // ======================================================================
    // Test sequence.
    initial begin
        logic [7:0] b;
        logic [1:0] s;
        tmc_path_t p;
        do_reset(5);
        chk_defaults();
        $display("test defaults done");
        // Every listed state code with trim and divider-set patterns.
        for (int i = 0; i < 5; i++) begin
            b = {i[2:0], 2'b10, i[1:0], i[0]};
            wr(2'h0, b);
            `CHK(op_state_o, tmc_op_state_t'(i[2:0]))
            `CHK(osc_fine_trim_o, i[1:0])
            `CHK(divider_set_sel_o, i[0])
            `CHK(band_sel_o, 2'h2)
            rd(2'h0, b);
        end
        $display("test state done");
        // Modulation, path bits, slicer kinds and gain steps in one sweep.
        // The reserved slicer code is never written, so steps 3 and 7 reuse average.
        for (int i = 0; i < 8; i++) begin
            s = (i[1:0] == 2'h3) ? 2'h2 : i[1:0];
            b = {(i[0] ? 2'b01 : 2'b10), i[1], s, i[2], i[1:0]};
            p = i[2] ? TMC_PATH_PACKET : (i[1] ? TMC_PATH_BUFFERED : TMC_PATH_CONTINUOUS);
            wr(2'h1, b);
            `CHK(modulation_o, (i[0] ? TMC_MOD_OOK : TMC_MOD_FSK))
            `CHK(datapath_o, p)
            `CHK(onoff_slicer_kind_o, tmc_slicer_t'(s))
            `CHK(if_gain_step_o, i[1:0])
            `CHK(if_atten_tenth_db_o, 8'(i[1:0] * 45))
            rd(2'h1, b);
        end
        $display("test modulation done");
        // Deviation and bit-rate codes at both ends of their ranges.
        for (int i = 0; i < 2; i++) begin
            wr(2'h2, (i == 0) ? 8'h00 : 8'hFF);
            wr(2'h3, (i == 0) ? 8'h00 : 8'h7F);
            `CHK(deviation_divisor_o, 14'(32 * (i * 255 + 1)))
            `CHK(fsk_deviation_code_o, 8'(i * 255))
            `CHK(bitrate_clock_divisor_o, 14'(64 * (i * 127 + 1)))
            `CHK(bitrate_divisor_o, 7'(i * 127))
            rd(2'h3, 8'(i * 127));
        end
        $display("test divisors done");
        // Read and write of one byte at the same edge returns the old value.
        @(negedge clock_i);
        rd_en_i = 1'b1;
        wr_en_i = 1'b1;
        addr_i = 2'h2;
        wdata_i = 8'h5A;
        @(negedge clock_i);
        rd_en_i = 1'b0;
        wr_en_i = 1'b0;
        `CHK(rdata_o, 8'hFF)
        `CHK(deviation_divisor_o, 14'(32 * 91))
        wr(2'h3, 8'h01);
        `CHK(rdata_o, 8'hFF)
        rd(2'h2, 8'h5A);
        $display("test same cycle done");
        // A second reset in mid-run restores every default.
        do_reset(1);
        chk_defaults();
        $display("test second reset done");
        close_out();
    end

endmodule // tmc_main_config_regs_tb
